/* File: design/mppr_params.svh */
`ifndef MPPR_PARAMS_SVH
`define MPPR_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MPPR_OFS_CTRL      4'h0
`define MPPR_OFS_ADDR      4'h4
`define MPPR_OFS_CMD       4'h8
`define MPPR_OFS_DATA      4'hc

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define MPPR_CTRL_W        9
`define MPPR_CTRL_WIDE     0
`define MPPR_CTRL_DCC_LSB  1
`define MPPR_CTRL_DCC_MSB  5
`define MPPR_CTRL_HOLD     6
`define MPPR_CTRL_FLASH    7
`define MPPR_CTRL_ALE_LOW  8
`define MPPR_CTRL_RST      9'h002

// ----------------------------------------
// Command and status fields
// ----------------------------------------
`define MPPR_CMD_START     0
`define MPPR_STAT_BUSY     0
`define MPPR_STAT_DONE     1
`define MPPR_ADDR_RST      16'h0000

// ----------------------------------------
// Phase lengths in peripheral clocks
// ----------------------------------------
`define MPPR_PCLK_RATIO    2
`define MPPR_ALE_PCLKS     5'h02
`define MPPR_SETUP_PCLKS   5'h02
`define MPPR_HOLD_PCLKS    5'h01
`define MPPR_FLASH_PCLKS   5'h07
`define MPPR_GAP_PCLKS     5'h01
`define MPPR_DRIVE_LEFT    5'h01
`define MPPR_CAP_TAP       1

`endif

/* File: design/mppr_pkg.sv */
package mppr_pkg;

  typedef enum logic [2:0] {
    MPPR_IDLE   = 3'h0,
    MPPR_ALE    = 3'h1,
    MPPR_SETUP  = 3'h3,
    MPPR_STROBE = 3'h2,
    MPPR_HOLD   = 3'h6,
    MPPR_FLASH  = 3'h7,
    MPPR_GAP    = 3'h5
  } mppr_state_t;

  typedef struct packed {
    mppr_state_t st;
    logic [4:0]  cnt;
    logic [8:0]  ctrl;
    logic [8:0]  run;
    logic [15:0] addr;
    logic [15:0] rdata;
    logic        pend;
    logic        busy;
    logic        done;
    logic [1:0]  cap;
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic        ale;
    logic        rd_n;
    logic [15:0] ad;
    logic [1:0]  oe_n;
    logic        ack;
    logic [31:0] dat;
  } mppr_regs_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } mppr_div_regs_t;

endpackage

/* File: design/mppr_tick_if.sv */
`timescale 1ns/1ps
interface mppr_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input  tick);
endinterface

/* File: design/mppr_pclk_div.sv */
`timescale 1ns/1ps
`include "mppr_params.svh"
module mppr_pclk_div #(
  parameter int RATIO = `MPPR_PCLK_RATIO
) (
  input  wire logic   clock_i,
  input  wire logic   rst_n_i,
  mppr_tick_if.src    tick_if
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  generate
    if (RATIO < 2 || RATIO > 16) begin : g_bad_ratio
      $error("mppr_pclk_div: RATIO out of range");
    end
  endgenerate

  localparam logic [3:0] LAST = 4'(RATIO - 1);

  mppr_pkg::mppr_div_regs_t q;
  mppr_pkg::mppr_div_regs_t d;

  // ----------------------------------------
  // Peripheral clock phase
  // ----------------------------------------
  // One tick per peripheral clock, free running
  always_comb begin
    d      = q;
    d.tick = (q.cnt == LAST);
    d.cnt  = (q.cnt == LAST) ? 4'h0 : q.cnt + 4'h1;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_if.tick = q.tick;

endmodule

/* File: design/mppr_top.sv */
`timescale 1ns/1ps
`include "mppr_params.svh"
// Behaviour
// - Sequencer counts peripheral clocks, two core clocks.
// - Read strobe lasts data-cycle-count peripheral clocks, one clock for a count of zero.
// - Optional single hold clock after strobe.
// - Flash mode adds seven recovery clocks.
// - Address latch strobe active high after reset, programmable.
// - Two clocks from latch end to strobe.
// - Gap between strobes: one clock plus hold.
// - Address released one clock after latch ends.
// - Narrow memory: upper byte held through hold.
// - No address drive until recovery finishes.
// - Data captured at strobe rising edge.
module mppr_top (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] ad_i,
  output logic      [15:0] ad_o,
  output logic      [1:0]  ad_oe_n_o,
  output logic             ale_o,
  output logic             rd_n_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Pin level of the latch strobe for a given polarity
  function automatic logic ale_level(input logic active, input logic low_pol);
    ale_level = active ^ low_pol;
  endfunction

  // Counter preload for a phase of n peripheral clocks
  function automatic logic [4:0] span(input logic [4:0] n);
    span = (n == 5'h00) ? 5'h00 : n - 5'h01;
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdat,
                                          input logic [3:0]  sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = wdat[15:8];
    end
  endfunction

  // ----------------------------------------
  // Peripheral clock tick
  // ----------------------------------------
  mppr_tick_if tick_bus ();

  mppr_pclk_div #(
    .RATIO (`MPPR_PCLK_RATIO)
  ) u_div (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .tick_if (tick_bus)
  );

  mppr_pkg::mppr_regs_t q;
  mppr_pkg::mppr_regs_t d;

  logic        tick;
  logic        req;
  logic        wr;
  logic        start;
  logic        clr_done;
  logic [3:0]  ofs;
  logic        wide;
  logic        hold_en;
  logic        flash_en;
  logic        low_pol;
  logic [4:0]  dcc;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Phase counters preload n - 1, so a zero-length phase cannot exist
  generate
    if (`MPPR_CTRL_ALE_LOW >= `MPPR_CTRL_W || `MPPR_CTRL_DCC_MSB >= `MPPR_CTRL_W) begin : g_bad_field
      $error("mppr_top: control field outside the control word");
    end
    if (`MPPR_CTRL_DCC_MSB - `MPPR_CTRL_DCC_LSB + 1 != $bits(dcc)) begin : g_bad_count
      $error("mppr_top: data cycle count field does not fit its counter");
    end
    if (`MPPR_ALE_PCLKS == 5'h00 || `MPPR_SETUP_PCLKS == 5'h00) begin : g_bad_latch
      $error("mppr_top: latch and setup phases need at least one clock");
    end
    if (`MPPR_HOLD_PCLKS == 5'h00 || `MPPR_GAP_PCLKS == 5'h00 || `MPPR_FLASH_PCLKS == 5'h00) begin : g_bad_rec
      $error("mppr_top: recovery phases need at least one clock");
    end
    if (`MPPR_DRIVE_LEFT >= `MPPR_SETUP_PCLKS) begin : g_bad_release
      $error("mppr_top: address release must fall inside the setup phase");
    end
    if (`MPPR_CAP_TAP >= $bits(d.cap)) begin : g_bad_tap
      $error("mppr_top: capture tap outside the delay line");
    end
  endgenerate

  assign tick     = tick_bus.tick;
  assign req      = wb_cyc_i & wb_stb_i;
  assign ofs      = {wb_adr_i[3:2], 2'b00};
  // Writes land on the edge at which the master sees ack
  assign wr       = req & wb_we_i & q.ack;
  assign start    = wr & (ofs == `MPPR_OFS_CMD) & wb_sel_i[0]
                  & wb_dat_i[`MPPR_CMD_START];
  assign clr_done = wr & (ofs == `MPPR_OFS_CMD) & wb_sel_i[0]
                  & wb_dat_i[`MPPR_STAT_DONE];
  // Access runs on a snapshot; control writes mid-read apply to the next start
  assign wide     = q.run[`MPPR_CTRL_WIDE];
  assign hold_en  = q.run[`MPPR_CTRL_HOLD];
  assign flash_en = q.run[`MPPR_CTRL_FLASH];
  assign low_pol  = q.run[`MPPR_CTRL_ALE_LOW];
  assign dcc      = q.run[`MPPR_CTRL_DCC_MSB:`MPPR_CTRL_DCC_LSB];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    // One wait state; ack drops after one cycle
    d.ack = req & ~q.ack;
    d.dat = 32'h0000_0000;
    if (req & ~q.ack & ~wb_we_i) begin
      unique case (ofs)
        `MPPR_OFS_CTRL: d.dat[8:0]  = q.ctrl;
        `MPPR_OFS_ADDR: d.dat[15:0] = q.addr;
        `MPPR_OFS_CMD: begin
          d.dat[`MPPR_STAT_BUSY] = q.busy;
          d.dat[`MPPR_STAT_DONE] = q.done;
        end
        `MPPR_OFS_DATA: d.dat[15:0] = q.rdata;
        default:        d.dat      = 32'h0000_0000;
      endcase
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (wr && ofs == `MPPR_OFS_CTRL) begin
      if (wb_sel_i[0]) begin
        d.ctrl[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        d.ctrl[8] = wb_dat_i[8];
      end
    end
    if (wr && ofs == `MPPR_OFS_ADDR && !q.busy) begin
      d.addr = merge16(q.addr, wb_dat_i, wb_sel_i);
    end

    // ----------------------------------------
    // Start command
    // ----------------------------------------
    // Start while busy is ignored
    if (start && !q.busy) begin
      d.pend = 1'b1;
      d.busy = 1'b1;
      d.run  = q.ctrl;
    end

    // ----------------------------------------
    // Data capture
    // ----------------------------------------
    // Pin synchroniser; only stage two feeds logic
    d.sync1 = ad_i;
    d.sync2 = q.sync1;

    // Capture two core clocks after the strobe edge, so the
    // second stage then holds the pins as they stood at it
    d.cap = {q.cap[0], 1'b0};
    if (q.cap[`MPPR_CAP_TAP]) begin
      d.rdata = wide ? q.sync2 : {8'h00, q.sync2[7:0]};
    end

    // ----------------------------------------
    // Done flag
    // ----------------------------------------
    // A capture in the clearing cycle wins
    if (clr_done) begin
      d.done = 1'b0;
    end
    if (q.cap[`MPPR_CAP_TAP]) begin
      d.done = 1'b1;
    end

    // ----------------------------------------
    // Read sequencer, one step per tick
    // ----------------------------------------
    if (q.st == mppr_pkg::MPPR_IDLE) begin
      d.ale = ale_level(1'b0, q.ctrl[`MPPR_CTRL_ALE_LOW]);
    end

    if (tick) begin
      unique case (q.st)
        mppr_pkg::MPPR_IDLE: begin
          if (q.pend) begin
            d.pend = 1'b0;
            d.st   = mppr_pkg::MPPR_ALE;
            d.cnt  = span(`MPPR_ALE_PCLKS);
            d.ale  = ale_level(1'b1, low_pol);
            d.ad   = q.addr;
            d.oe_n = 2'b00;
          end
        end

        mppr_pkg::MPPR_ALE: begin
          if (q.cnt != 5'h00) begin
            d.cnt = q.cnt - 5'h01;
          end else begin
            d.st  = mppr_pkg::MPPR_SETUP;
            d.cnt = span(`MPPR_SETUP_PCLKS);
            d.ale = ale_level(1'b0, low_pol);
          end
        end

        mppr_pkg::MPPR_SETUP: begin
          // Address held one clock past the latch edge
          if (q.cnt == `MPPR_DRIVE_LEFT) begin
            d.oe_n[0] = 1'b1;
            d.oe_n[1] = wide;
          end
          if (q.cnt != 5'h00) begin
            d.cnt = q.cnt - 5'h01;
          end else begin
            d.st   = mppr_pkg::MPPR_STROBE;
            // A zero count still gives one clock of strobe
            d.cnt  = span(dcc);
            d.rd_n = 1'b0;
          end
        end

        mppr_pkg::MPPR_STROBE: begin
          if (q.cnt != 5'h00) begin
            d.cnt = q.cnt - 5'h01;
          end else begin
            d.rd_n = 1'b1;
            d.cap  = {q.cap[0], 1'b1};
            if (hold_en) begin
              d.st  = mppr_pkg::MPPR_HOLD;
              d.cnt = span(`MPPR_HOLD_PCLKS);
            end else begin
              d.oe_n[1] = 1'b1;
              if (flash_en) begin
                d.st  = mppr_pkg::MPPR_FLASH;
                d.cnt = span(`MPPR_FLASH_PCLKS);
              end else begin
                d.st  = mppr_pkg::MPPR_GAP;
                d.cnt = span(`MPPR_GAP_PCLKS);
              end
            end
          end
        end

        mppr_pkg::MPPR_HOLD: begin
          if (q.cnt != 5'h00) begin
            d.cnt = q.cnt - 5'h01;
          end else begin
            // Upper byte released when the hold clock ends
            d.oe_n[1] = 1'b1;
            if (flash_en) begin
              d.st  = mppr_pkg::MPPR_FLASH;
              d.cnt = span(`MPPR_FLASH_PCLKS);
            end else begin
              d.st  = mppr_pkg::MPPR_GAP;
              d.cnt = span(`MPPR_GAP_PCLKS);
            end
          end
        end

        mppr_pkg::MPPR_FLASH: begin
          if (q.cnt != 5'h00) begin
            d.cnt = q.cnt - 5'h01;
          end else begin
            d.st  = mppr_pkg::MPPR_GAP;
            d.cnt = span(`MPPR_GAP_PCLKS);
          end
        end

        mppr_pkg::MPPR_GAP: begin
          // Lines stay released until the next latch phase
          if (q.cnt != 5'h00) begin
            d.cnt = q.cnt - 5'h01;
          end else begin
            d.st   = mppr_pkg::MPPR_IDLE;
            d.busy = 1'b0;
          end
        end

        default: begin
          d.st   = mppr_pkg::MPPR_IDLE;
          d.cnt  = 5'h00;
          d.rd_n = 1'b1;
          d.oe_n = 2'b11;
          d.busy = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q      <= '0;
      q.st   <= mppr_pkg::MPPR_IDLE;
      q.ctrl <= `MPPR_CTRL_RST;
      q.run  <= `MPPR_CTRL_RST;
      q.addr <= `MPPR_ADDR_RST;
      q.rd_n <= 1'b1;
      q.oe_n <= 2'b11;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_ack_o  = q.ack;
  assign wb_dat_o  = q.dat;
  assign ad_o      = q.ad;
  assign ad_oe_n_o = q.oe_n;
  assign ale_o     = q.ale;
  assign rd_n_o    = q.rd_n;

endmodule

/* File: verif/mppr_monitor.sv */
`timescale 1ns/1ps
module mppr_monitor (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [15:0] ad_i,
  input wire logic [15:0] ad_o,
  input wire logic [1:0]  ad_oe_n_o,
  input wire logic        ale_o,
  input wire logic        rd_n_o
);
  // ----------
  // Shadow of control, strobe and recovery counters
  // ----------
  logic [8:0] ctrl_q;
  logic [6:0] low_q;
  logic [7:0] since_q;
  logic [6:0] wid;
  logic [7:0] rec;
  assign wid = (ctrl_q[5:1] == 5'h00) ? 7'h02 : {1'b0, ctrl_q[5:1], 1'b0};
  assign rec = 8'h02 + (ctrl_q[6] ? 8'h02 : 8'h00) + (ctrl_q[7] ? 8'h0e : 8'h00);
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q  <= 9'h002;
      low_q   <= 7'h00;
      since_q <= 8'hff;
    end else begin
      if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i[3:2] == 2'h0) begin
        if (wb_sel_i[0]) ctrl_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) ctrl_q[8] <= wb_dat_i[8];
      end
      low_q   <= rd_n_o ? 7'h00 : low_q + 7'h01;
      since_q <= rd_n_o ? ((since_q == 8'hff) ? 8'hff : since_q + 8'h01) : 8'h00;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ----------
  // Checks, counted in core clocks
  // ----------
  a_ale_two_pclk: assert property ($fell(ad_oe_n_o[1]) |-> $changed(ale_o) ##1 $stable(ale_o)[*3] ##1 $changed(ale_o))
    else $error("latch strobe not two peripheral clocks");
  a_ale_level: assert property ($fell(ad_oe_n_o[1]) |-> ale_o == !ctrl_q[8])
    else $error("latch strobe level wrong");
  a_rd_after_ale: assert property ($fell(ad_oe_n_o[1]) |-> ##4 rd_n_o[*4] ##1 !rd_n_o)
    else $error("read strobe not two clocks after latch end");
  a_addr_release: assert property ($fell(ad_oe_n_o[1]) |-> ##4 (!ad_oe_n_o[0])[*2] ##1 ad_oe_n_o[0])
    else $error("low lane release time wrong");
  a_lane_drive: assert property (!rd_n_o |-> ad_oe_n_o == {ctrl_q[0], 1'b1})
    else $error("lane drive wrong during read");
  a_lane_hold: assert property ($rose(rd_n_o) && !ctrl_q[0] |-> (ad_oe_n_o[1] == !ctrl_q[6])[*2])
    else $error("upper byte hold wrong");
  a_rd_width: assert property ($rose(rd_n_o) |-> low_q == wid)
    else $error("read strobe width wrong");
  a_rd_gap: assert property ($fell(rd_n_o) |-> since_q >= (ctrl_q[6] ? 8'h04 : 8'h02))
    else $error("read strobes too close");
  a_drive_again: assert property ($fell(ad_oe_n_o[1]) |-> since_q >= rec)
    else $error("address driven before recovery");
  a_pclk_align: assert property ($changed(rd_n_o) |=> $stable(rd_n_o))
    else $error("read strobe off peripheral clock");
  a_ack_pulse: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
endmodule
bind mppr_top mppr_monitor u_mon (.clock_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .ad_i, .ad_o, .ad_oe_n_o, .ale_o, .rd_n_o);

/* File: verif/mppr_mem_model.sv */
`timescale 1ns/1ps
module mppr_mem_model (
  input  wire logic        clock_i,
  input  wire logic        ale_low_i,
  input  wire logic        slow_i,
  input  wire logic        ale_i,
  input  wire logic        rd_n_i,
  input  wire logic [15:0] bus_i,
  output logic      [15:0] drv_o
);
  logic [15:0] addr_q;
  logic [15:0] pat_q   = 16'h0001;
  logic        first_q = 1'b1;
  // ----------
  // Address taken at the trailing edge of the latch strobe
  // ----------
  always @(negedge (ale_i ^ ale_low_i)) begin
    addr_q = bus_i;
  end
  // Released lines wander so a stale sample never passes
  always @(posedge clock_i) begin
    pat_q   <= {pat_q[14:0], ~pat_q[15]};
    first_q <= rd_n_i;
  end
  // Slow parts are valid only from the second clock of the strobe
  assign drv_o = (!rd_n_i && !(slow_i && first_q)) ? ~{addr_q[7:0], addr_q[15:8]} : pat_q;
endmodule

/* File: verif/mppr_tb_top.sv */
`timescale 1ns/1ps
module mppr_tb_top;
  logic        clock_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ale_o, rd_n_o, ale_low, slow;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, seed, r;
  logic [15:0] ad_i, ad_o, mem_w, addr, expd;
  logic [1:0]  ad_oe_n_o;
  logic [8:0]  ctrl;
  int          failures, check_count, n, strobes;
  logic [15:0] exp_q[$];
  logic [8:0]  tab[3] = '{9'h002, 9'h1ff, 9'h0c0};
  mppr_top DUT (.clock_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .ad_i, .ad_o, .ad_oe_n_o, .ale_o, .rd_n_o);
  mppr_mem_model mem (.clock_i, .ale_low_i(ale_low), .slow_i(slow), .ale_i(ale_o), .rd_n_i(rd_n_o), .bus_i(ad_i),
    .drv_o(mem_w));
  assign ad_i = {ad_oe_n_o[1] ? mem_w[15:8] : ad_o[15:8], ad_oe_n_o[0] ? mem_w[7:0] : ad_o[7:0]};
  // Read strobes seen on the pins, one per accepted start
  always @(negedge rd_n_o) begin
    strobes++;
  end
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // ----------
  // Helpers
  // ----------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= we ? 4'h3 : seed[7:4];
    do begin
      @(posedge clock_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    r = wb_dat_o;
    if (wb_ack_o !== 1'b1) begin
      chk(16'h0000, 16'h0001, "no ack");
      wrap_up();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock_i);
  endtask
  // Hang guard
  initial begin
    repeat (90000) @(posedge clock_i);
    chk(16'h0000, 16'h0001, "timeout");
    wrap_up();
  end
  // ----------
  // Main sequence
  // ----------
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, ale_low, slow} = 5'h00;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    failures = 0;
    check_count = 0;
    seed = 32'h00000013;
    rst_n_i = 1'b0;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    chk({15'h0000, ale_o}, 16'h0000, "latch idle");
    wb(1'b0, 4'h1, 32'h00000000);
    chk(r[15:0], 16'h0002, "control reset");
    for (int i = 0; i < 30; i++) begin
      seed = xs(seed);
      ctrl = (i < 3) ? tab[i] : seed[8:0];
      addr = seed[31:16];
      slow <= seed[9];
      ale_low <= ctrl[8];
      wb(1'b1, 4'h0, {23'h000000, ctrl});
      wb(1'b1, 4'h4, {16'h0000, addr});
      expd = ~{addr[7:0], addr[15:8]};
      exp_q.push_back(ctrl[0] ? expd : {8'h00, expd[7:0]});
      wb(1'b1, 4'h8, 32'h00000001);
      wb(1'b1, 4'h4, {16'h0000, ~addr});
      wb(1'b1, 4'h8, 32'h00000001);
      wb(1'b0, 4'h8, 32'h00000000);
      chk({14'h0000, r[1:0]}, 16'h0001, "busy");
      n = 0;
      do begin
        wb(1'b0, 4'h8, 32'h00000000);
        n++;
      end while (r[1:0] !== 2'b10 && n < 100);
      chk({14'h0000, r[1:0]}, 16'h0002, "completion");
      wb(1'b0, 4'hc, 32'h00000000);
      chk(r[15:0], exp_q.pop_front(), "read data");
      wb(1'b0, 4'h4, 32'h00000000);
      chk(r[15:0], addr, "address kept");
      wb(1'b1, 4'h8, 32'h00000002);
      wb(1'b0, 4'h8, 32'h00000000);
      chk({15'h0000, r[1]}, 16'h0000, "done cleared");
      chk(strobes[15:0], 16'(i + 1), "strobe count");
    end
    wrap_up();
  end
endmodule
